// file: design/aicd_pkg.sv
// package for the converter input configuration decoder
// assumes a single pclk domain and an apb register port
package aicd_pkg;
  // register byte offsets
  localparam logic [7:0] AICD_OFS_CONFIG = 8'h00;
  localparam logic [7:0] AICD_OFS_STATUS = 8'h04;
  localparam logic [7:0] AICD_OFS_IRQ_STAT = 8'h08;
  localparam logic [7:0] AICD_OFS_IRQ_EN = 8'h0C;
  localparam logic [7:0] AICD_OFS_IRQ_CLR = 8'h10;
  localparam logic [7:0] AICD_OFS_SETTLE = 8'h14;
  // config_reg field positions
  localparam int AICD_POS_CHOP = 23;
  localparam int AICD_POS_PSEUDO = 18;
  localparam int AICD_POS_CH_HI = 17;
  localparam int AICD_POS_CH_LO = 8;
  localparam int AICD_POS_BURN = 7;
  localparam int AICD_POS_REFCHK = 6;
  localparam int AICD_POS_RSVD5 = 5;
  localparam int AICD_POS_BUF = 4;
  localparam int AICD_POS_UNIPOLAR = 3;
  localparam int AICD_NUM_SRC = 10;
  // reset values
  localparam logic [23:0] AICD_RST_CONFIG = 24'h000000;
  localparam logic [15:0] AICD_RST_SETTLE = 16'h0010;
  // interrupt status bit positions
  localparam int AICD_IRQ_RESULT = 0;
  localparam int AICD_IRQ_MISSING_REFERENCE_FLAG = 1;
  localparam int AICD_IRQ_CFGERR = 2;
  localparam int AICD_IRQ_W = 3;
  // sequencer states
  typedef enum logic [1:0] {AICD_IDLE, AICD_SETTLE, AICD_NEXT} aicd_state_t;
endpackage

// file: design/aicd_top.sv
// input configuration decoder with channel sequencer and apb registers
// assumes apb master in pclk domain; analog status comes in synchronous
// How it works
// - bit 18 selects pseudo or full differential
// - sequence every enabled source automatically
// - each source waits full settling period
// - bit 7 switches open-wire test currents
// - test current needs buffer on, chop off
// - bit 6 enables missing reference flag
// - reference check only while converting
// - bit 4 routes inputs through buffers
// - bit 3 selects unipolar coding
// - bit 23 enables input chopping
`timescale 1ns/1ps
module aicd_top
  import aicd_pkg::*;
(
  // clock and reset
  input wire logic pclk,
  input wire logic presetn,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // converter side
  input wire logic conv_active,
  input wire logic ref_low,
  // decoded controls
  output logic pseudo_diff,
  output logic [9:0] src_select,
  output logic result_strobe,
  output logic burnout_en,
  output logic missing_reference_flag,
  output logic buffer_en,
  output logic unipolar,
  output logic chop_en,
  output logic irq
);

  // register state
  logic [23:0] config_q;
  logic [15:0] settle_q;
  logic [AICD_IRQ_W-1:0] istat_q, istat_d, ien_q;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;
  // sequencer state
  aicd_state_t state_q, state_d;
  logic [15:0] cnt_q, cnt_d;
  logic [3:0] idx_q, idx_d;
  logic strobe_q, strobe_d;
  logic missing_reference_flag_q;
  logic [9:0] src_q;
  logic irq_q;
  logic [4:0] dec_q;

  // lowest enabled index at or above start, wrapping
  function automatic logic [3:0] next_src(input logic [9:0] en, input logic [3:0] start);
    logic [3:0] r;
    logic [4:0] k;
    r = start;
    for (int i = AICD_NUM_SRC - 1; i >= 0; i--) begin
      k = 5'(start) + 5'(i);
      if (k >= 5'(AICD_NUM_SRC)) begin
        k = k - 5'(AICD_NUM_SRC);
      end
      if (en[k[3:0]]) begin
        r = k[3:0];
      end
    end
    return r;
  endfunction

  // apb decode
  wire setup_ph = psel && !penable;
  wire access_ph = psel && penable;
  wire wr_en = access_ph && pwrite && pready_q;
  wire hit_cfg = paddr == AICD_OFS_CONFIG;
  wire hit_sts = paddr == AICD_OFS_STATUS;
  wire hit_ist = paddr == AICD_OFS_IRQ_STAT;
  wire hit_ien = paddr == AICD_OFS_IRQ_EN;
  wire hit_icl = paddr == AICD_OFS_IRQ_CLR;
  wire hit_set = paddr == AICD_OFS_SETTLE;
  wire mapped = hit_cfg | hit_sts | hit_ist | hit_ien | hit_icl | hit_set;
  wire cfg_wr = wr_en && hit_cfg;
  // settle period write, also restarts the sequencer
  wire set_wr = wr_en && hit_set;
  wire [9:0] ch_en = config_q[AICD_POS_CH_HI:AICD_POS_CH_LO];
  // one-hot check, only a hint since sw owns this
  wire one_src = (ch_en != 10'h000) && ((ch_en & (ch_en - 10'h001)) == 10'h000);
  // writing the reserved bit as one is flagged
  wire cfg_err = cfg_wr && pwdata[AICD_POS_RSVD5];
  wire [31:0] status_word = {22'h0, one_src, missing_reference_flag_q, idx_q, 1'b0, state_q != AICD_IDLE,
    2'h0};
  wire [31:0] rd_mux = hit_cfg ? {8'h00, config_q} :
    hit_sts ? status_word :
    hit_ist ? {29'h0, istat_q} :
    hit_ien ? {29'h0, ien_q} :
    hit_set ? {16'h0000, settle_q} : 32'h0;

  // apb answer: no wait state, ready lands in the first access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= setup_ph;
      pslverr_q <= setup_ph && !mapped;
      // read data latched during setup so it is stable at ready
      prdata_q <= (setup_ph && !pwrite) ? rd_mux : 32'h00000000;
    end
  end

  // configuration and settle registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      config_q <= AICD_RST_CONFIG;
      settle_q <= AICD_RST_SETTLE;
      ien_q <= '0;
    end else begin
      if (cfg_wr) begin
        config_q <= pwdata[23:0];
      end
      if (set_wr) begin
        // zero period would mean no settling, clamp to one
        settle_q <= (pwdata[15:0] == 16'h0000) ? 16'h0001 : pwdata[15:0];
      end
      if (wr_en && hit_ien) begin
        ien_q <= pwdata[AICD_IRQ_W-1:0];
      end
    end
  end

  // sequencer: visit each enabled source, full settle on each
  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    idx_d = idx_q;
    strobe_d = 1'b0;
    unique case (state_q)
      AICD_IDLE: begin
        // start when converting and any source enabled
        if (conv_active && ch_en != 10'h000 && !set_wr) begin
          state_d = AICD_SETTLE;
          idx_d = next_src(ch_en, 4'h0);
          cnt_d = settle_q;
        end
      end
      AICD_SETTLE: begin
        if (!conv_active || ch_en == 10'h000 || cfg_wr || set_wr) begin
          // config change restarts so a result never mixes settings
          // a new period restarts too, so each visit uses one period
          state_d = AICD_IDLE;
        end else if (cnt_q == 16'h0001) begin
          state_d = AICD_NEXT;
          strobe_d = 1'b1;
        end else begin
          cnt_d = cnt_q - 16'h0001;
        end
      end
      AICD_NEXT: begin
        // wrap to next enabled source, a single one repeats
        idx_d = next_src(ch_en, (idx_q == 4'd9) ? 4'h0 : idx_q + 4'h1);
        cnt_d = settle_q;
        state_d = (conv_active && !set_wr) ? AICD_SETTLE : AICD_IDLE;
      end
    endcase
  end

  // sequencer registers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= AICD_IDLE;
      cnt_q <= 16'h0000;
      idx_q <= 4'h0;
      strobe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      idx_q <= idx_d;
      strobe_q <= strobe_d;
    end
  end

  // reference flag held while idle, updated only when converting
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      missing_reference_flag_q <= 1'b0;
    end else if (conv_active) begin
      missing_reference_flag_q <= config_q[AICD_POS_REFCHK] && ref_low;
    end
  end

  // next flag value, held while idle
  wire missing_reference_flag_d = conv_active ? (config_q[AICD_POS_REFCHK] && ref_low) : missing_reference_flag_q;
  // only a fresh fault is an event, a held flag would defeat the clear
  wire missing_reference_flag_rise = missing_reference_flag_d && !missing_reference_flag_q;

  // sticky events; a set in the clear cycle wins
  wire [AICD_IRQ_W-1:0] ev = {cfg_err, missing_reference_flag_rise, strobe_q};
  wire [AICD_IRQ_W-1:0] clr = (wr_en && hit_icl) ? pwdata[AICD_IRQ_W-1:0] : '0;
  assign istat_d = (istat_q & ~clr) | ev;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      istat_q <= '0;
      irq_q <= 1'b0;
    end else begin
      istat_q <= istat_d;
      irq_q <= |(istat_d & ien_q);
    end
  end

  // decoded control outputs, registered from stored config and sequencer state
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dec_q <= 5'h00;
      src_q <= 10'h000;
    end else begin
      dec_q[0] <= config_q[AICD_POS_PSEUDO];
      dec_q[1] <= config_q[AICD_POS_BURN] && config_q[AICD_POS_BUF] &&
        !config_q[AICD_POS_CHOP];
      dec_q[2] <= config_q[AICD_POS_BUF];
      dec_q[3] <= config_q[AICD_POS_UNIPOLAR];
      dec_q[4] <= config_q[AICD_POS_CHOP];
      src_q <= (state_q == AICD_SETTLE) ? (10'h001 << idx_q) : 10'h000;
    end
  end

  // outputs straight from flops
  assign prdata = prdata_q;
  assign pready = pready_q;
  assign pslverr = pslverr_q;
  assign pseudo_diff = dec_q[0];
  assign burnout_en = dec_q[1];
  assign buffer_en = dec_q[2];
  assign unipolar = dec_q[3];
  assign chop_en = dec_q[4];
  assign src_select = src_q;
  assign result_strobe = strobe_q;
  assign missing_reference_flag = missing_reference_flag_q;
  assign irq = irq_q;

  // assertions
  property p_burn_gate;
    @(posedge pclk) disable iff (!presetn)
      burnout_en |-> $past(config_q[AICD_POS_BUF]) && !$past(config_q[AICD_POS_CHOP]);
  endproperty
  a_burn_gate: assert property (p_burn_gate) else $error("burnout without gate");
  property p_burn_on;
    @(posedge pclk) disable iff (!presetn)
      (config_q[AICD_POS_BURN] && config_q[AICD_POS_BUF] && !config_q[AICD_POS_CHOP])
        |=> burnout_en;
  endproperty
  a_burn_on: assert property (p_burn_on) else $error("burnout not enabled");
  property p_cfg_follow;
    @(posedge pclk) disable iff (!presetn)
      cfg_wr |=> ##1 (pseudo_diff == $past(pwdata[AICD_POS_PSEUDO], 2)) &&
        (unipolar == $past(pwdata[AICD_POS_UNIPOLAR], 2));
  endproperty
  a_cfg_follow: assert property (p_cfg_follow) else $error("no follow");
  property p_buf;
    @(posedge pclk) disable iff (!presetn) ##1 buffer_en == $past(config_q[AICD_POS_BUF]);
  endproperty
  a_buf: assert property (p_buf) else $error("buffer enable wrong");
  property p_chop;
    @(posedge pclk) disable iff (!presetn) ##1 chop_en == $past(config_q[AICD_POS_CHOP]);
  endproperty
  a_chop: assert property (p_chop) else $error("chop enable wrong");
  property p_missing_reference_flag_hold;
    @(posedge pclk) disable iff (!presetn) !conv_active |=> $stable(missing_reference_flag);
  endproperty
  a_missing_reference_flag_hold: assert property (p_missing_reference_flag_hold) else $error("flag moved idle");
  property p_missing_reference_flag_en;
    @(posedge pclk) disable iff (!presetn)
      (conv_active && !config_q[AICD_POS_REFCHK]) |=> !missing_reference_flag;
  endproperty
  a_missing_reference_flag_en: assert property (p_missing_reference_flag_en) else $error("flag without enable");
  // cycles spent on the current source, checked against the period
  logic [15:0] dwell_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dwell_q <= 16'h0000;
    end else begin
      dwell_q <= (state_q == AICD_SETTLE) ? dwell_q + 16'h0001 : 16'h0000;
    end
  end
  property p_settle;
    @(posedge pclk) disable iff (!presetn)
      result_strobe |-> dwell_q == settle_q;
  endproperty
  a_settle: assert property (p_settle) else $error("result before settle");
  property p_seq;
    @(posedge pclk) disable iff (!presetn)
      (state_q == AICD_NEXT) |=> (!conv_active || ch_en[idx_q] || $changed(ch_en) ||
        $past(cfg_wr));
  endproperty
  a_seq: assert property (p_seq) else $error("disabled source chosen");
  c_result: cover property (@(posedge pclk) disable iff (!presetn) result_strobe);
  c_multi: cover property (@(posedge pclk) disable iff (!presetn)
    result_strobe && !one_src);
  c_irq: cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
endmodule

// file: testbench/aicd_top_tb.sv
// self-checking bench for the input configuration decoder
// assumes aicd_pkg and aicd_top from design/, one pclk domain
`timescale 1ns/1ps
`define CHK(nm, exp, got) begin tests_run++; if ((got) !== (exp)) begin n_mismatch++; \
  $display("mismatch %s exp %h got %h", nm, exp, got); end end
module aicd_top_tb;
  import aicd_pkg::*;
  // apb master side, all driven by nba after a rising edge
  logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, err;
  // converter status inputs
  logic conv_active = 0, ref_low = 0;
  // decoded outputs
  logic pseudo_diff, result_strobe, burnout_en, missing_reference_flag;
  logic buffer_en, unipolar, chop_en, irq;
  logic [9:0] src_select;
  int n_mismatch = 0, tests_run = 0;

  aicd_top i_aicd_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .conv_active(conv_active), .ref_low(ref_low),
    .pseudo_diff(pseudo_diff), .src_select(src_select), .result_strobe(result_strobe),
    .burnout_en(burnout_en), .missing_reference_flag(missing_reference_flag),
    .buffer_en(buffer_en), .unipolar(unipolar), .chop_en(chop_en), .irq(irq));

  // 100 MHz clock
  always #5 pclk = ~pclk;

  // one apb transfer; the answer is taken at the edge that samples pready high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // no cycle count assumed, the watchdog ends a hung wait
    do begin
      @(posedge pclk);
    end while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // settle point one edge after a config write lands
  task automatic step;
    @(posedge pclk);
    #1;
  endtask

  // reset values and an unmapped address
  task automatic t_reset;
    `CHK("outs", 16'h0000,
      {pseudo_diff, src_select, burnout_en, buffer_en, unipolar, chop_en, irq})
    apb(1'b0, AICD_OFS_SETTLE, 32'h0);
    `CHK("settle", {16'h0, AICD_RST_SETTLE}, rd)
    apb(1'b1, 8'h40, 32'hFFFFFFFF);
    `CHK("err_wr", 1'b1, err)
    apb(1'b0, 8'h40, 32'h0);
    `CHK("err_rd", 33'h100000000, {err, rd})
    apb(1'b0, AICD_OFS_CONFIG, 32'h0);
    `CHK("config", 33'h0, {err, rd})
  endtask

  // field decode over a table of config words
  task automatic t_decode;
    logic [23:0] t [4] = '{24'h040098, 24'h800090, 24'h000080, 24'h000018};
    foreach (t[i]) begin
      apb(1'b1, AICD_OFS_CONFIG, {8'h00, t[i]});
      step;
      `CHK("pseudo", t[i][AICD_POS_PSEUDO], pseudo_diff)
      `CHK("burn", t[i][7] & t[i][4] & ~t[i][23], burnout_en)
      `CHK("buf", t[i][AICD_POS_BUF], buffer_en)
      `CHK("unipolar", t[i][AICD_POS_UNIPOLAR], unipolar)
      `CHK("chop", t[i][AICD_POS_CHOP], chop_en)
    end
  endtask

  // two sources sequenced, with wrap and result interrupt
  task automatic t_seq;
    logic [9:0] seen [$];
    logic [9:0] last = 10'h0;
    int gap = 0, nstb = 0;
    apb(1'b1, AICD_OFS_SETTLE, 32'h2);
    apb(1'b1, AICD_OFS_IRQ_EN, 32'h1);
    apb(1'b1, AICD_OFS_CONFIG, 32'h000910);
    conv_active <= 1'b1;
    for (int n = 0; n < 300 && seen.size() < 3; n++) begin
      @(negedge pclk);
      gap++;
      if (src_select !== 10'h0 && src_select !== last) seen.push_back(src_select);
      last = src_select;
      if (result_strobe === 1'b1) begin
        nstb++;
        `CHK("gap", 1'b1, 1'(gap >= 2))
        gap = 0;
      end
    end
    `CHK("order", 30'h00102001, {seen[0], seen[1], seen[2]})
    `CHK("nstb", 2, nstb)
    `CHK("irq_res", 1'b1, irq)
    @(posedge pclk);
    conv_active <= 1'b0;
    apb(1'b1, AICD_OFS_IRQ_CLR, 32'h1);
    step;
    `CHK("idle", 11'h000, {irq, src_select})
  endtask

  // reference check gated by conversion, masked then unmasked irq
  task automatic t_missing_reference_flag;
    // a single source, as calibration would need
    apb(1'b1, AICD_OFS_CONFIG, 32'h000140);
    ref_low <= 1'b1;
    repeat (4) step;
    `CHK("flag_idle", 1'b0, missing_reference_flag)
    @(posedge pclk);
    conv_active <= 1'b1;
    repeat (3) step;
    `CHK("flag_on", 2'b10, {missing_reference_flag, irq})
    @(posedge pclk);
    conv_active <= 1'b0;
    ref_low <= 1'b0;
    apb(1'b1, AICD_OFS_IRQ_EN, 32'h2);
    step;
    `CHK("flag_hold", 2'b11, {missing_reference_flag, irq})
    apb(1'b0, AICD_OFS_STATUS, 32'h0);
    `CHK("stat_missing_reference_flag", 1'b1, rd[8])
    `CHK("one_src", 1'b1, rd[9])
    apb(1'b1, AICD_OFS_IRQ_CLR, 32'h2);
    step;
    `CHK("irq_clr", 1'b0, irq)
    @(posedge pclk);
    conv_active <= 1'b1;
    repeat (3) step;
    `CHK("flag_off", 1'b0, missing_reference_flag)
    @(posedge pclk);
    conv_active <= 1'b0;
  endtask

  // reserved bit written as one, read-only status ignores writes
  task automatic t_rsvd;
    apb(1'b1, AICD_OFS_CONFIG, 32'h000020);
    apb(1'b1, AICD_OFS_IRQ_STAT, 32'h0);
    apb(1'b0, AICD_OFS_IRQ_STAT, 32'h0);
    `CHK("rsvd_evt", 1'b1, rd[AICD_IRQ_CFGERR])
    apb(1'b1, AICD_OFS_IRQ_CLR, 32'h4);
    apb(1'b0, AICD_OFS_IRQ_STAT, 32'h0);
    `CHK("rsvd_clr", 1'b0, rd[AICD_IRQ_CFGERR])
  endtask

  // verdict and end of run
  task automatic complete_run;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask

  // main sequence, reset held for six cycles
  initial begin
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    t_reset;
    t_decode;
    t_seq;
    t_missing_reference_flag;
    t_rsvd;
    complete_run;
  end

  // watchdog, far beyond the hundred or so cycles the tests need
  initial begin
    #100000;
    n_mismatch++;
    complete_run;
  end
endmodule
